// *** test/mm_fabric_model.sv ***
module mm_fabric_model
   import mm_slave_pkg::*;
(
   input  wire logic                   clk_in,
   input  wire mm_slave_pkg::bus_rsp_t rsp_in,
   output mm_slave_pkg::bus_req_t      req_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial req_out = '0;
   // ------------------------------------------------------------
   // fabric side, called at a falling edge
   // ------------------------------------------------------------
   task idle(input int n);
      repeat (n) begin
         req_out = {3'b011, ~req_out[43:0]};
         @(negedge clk_in);
      end
   endtask
   task timed(input bus_req_t r, input int su, wt,
              output logic [DATA_W-1:0] d);
      bus_req_t s;
      s = r;
      s.rd = 1'b0;
      s.wr = 1'b0;
      if (su > 0) begin
         req_out = s;
         repeat (su) @(negedge clk_in);
      end
      req_out = r;
      repeat (wt) @(negedge clk_in);
      d = rsp_in.rdata;
      @(negedge clk_in);
   endtask
   task xfer(input bus_req_t r, output logic [DATA_W-1:0] d);
      int n;
      n = 0;
      req_out = r;
      #1;
      while (rsp_in.stall !== 1'b0 && n < 300) begin
         @(negedge clk_in);
         #1;
         n++;
      end
      d = rsp_in.rdata;
      @(negedge clk_in);
   endtask
endmodule

// *** test/mm_slave_port_timing_test.sv ***
module mm_slave_port_timing_test;
   import mm_slave_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic             clk_in, sys_rst_in, busy;
   logic [CNT_W-1:0] dly;
   bus_req_t         req;
   bus_rsp_t         rsp;
   logic [31:0]      rdc, wrc, d;
   int               fail_count, samples_checked, cyc, st, t0;
   logic             busy2;
   bus_req_t         req2;
   bus_rsp_t         rsp2;
   logic [31:0]      rdc2, wrc2;

   mm_slave_port_timing #(
      .VAR_WAIT(1'b1), .SETUP(0), .WAITS(1), .HAS_LANES(1'b1)
   ) i_dut (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_in(req),
      .var_delay_in(dly), .rsp_out(rsp), .busy_out(busy),
      .rd_count_out(rdc), .wr_count_out(wrc));
   mm_fabric_model i_fab (.clk_in(clk_in), .rsp_in(rsp), .req_out(req));
   mm_slave_port_timing #(
      .VAR_WAIT(1'b0), .SETUP(1), .WAITS(1), .HAS_LANES(1'b1)
   ) i_fix (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_in(req2),
      .var_delay_in(dly), .rsp_out(rsp2), .busy_out(busy2),
      .rd_count_out(rdc2), .wr_count_out(wrc2));
   mm_fabric_model i_fab2 (.clk_in(clk_in), .rsp_in(rsp2), .req_out(req2));

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cyc++;
      if (rsp.stall === 1'b1) st++;
      if (cyc == 2000) begin
         fail_count++;
         stop_test();
      end
   end
   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   task chk(input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, n, input logic [3:0] l,
           input logic [31:0] v);
      dly = n;
      i_fab.xfer({3'b101, a, l, v}, d);
   endtask
   task rd(input logic [7:0] a);
      dly = 8'h02;
      i_fab.xfer({3'b110, a, 4'hF, 32'h0}, d);
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      sys_rst_in = 1'b1;
      dly = '0;
      repeat (12) @(posedge clk_in);
      @(negedge clk_in);
      sys_rst_in = 1'b0;
      wr(8'h05, 8'h00, 4'hF, 32'hAABBCCDD);
      chk(wrc, 32'h1);
      rd(8'h05);
      chk(d, 32'hAABBCCDD);
      $display("single write and read done");
      wr(8'h05, 8'h00, 4'h5, 32'h11223344);
      rd(8'h05);
      chk(d, 32'hAA22CC44);
      $display("byte lanes done");
      t0 = cyc;
      for (int i = 1; i < 5; i++) wr(8'(i), 8'h00, 4'hF, {4{8'(i)}});
      chk(32'(cyc - t0), 32'h4);
      chk(wrc, 32'h6);
      for (int i = 1; i < 5; i++) begin
         rd(8'(i));
         chk(d, {4{8'(i)}});
      end
      chk(rdc, 32'h6);
      $display("back to back done");
      t0 = st;
      wr(8'h20, 8'h03, 4'hF, 32'h5A5A5A5A);
      chk({31'h0, st > t0}, 32'h1);
      chk(wrc, 32'h7);
      chk({31'h0, busy}, 32'h0);
      $display("stalled write done");
      i_fab.idle(6);
      chk(wrc, 32'h7);
      rd(8'h20);
      chk(d, 32'h5A5A5A5A);
      $display("unselected done");
      t0 = cyc;
      i_fab2.timed({3'b101, 8'h09, 4'hF, 32'h600DF00D}, 1, 1, d);
      i_fab2.timed({3'b110, 8'h09, 4'hF, 32'h0}, 1, 1, d);
      chk(d, 32'h600DF00D);
      chk(32'(cyc - t0), 32'h6);
      chk(rdc2, 32'h2);
      chk(wrc2, 32'h2);
      chk({31'h0, rsp2.stall}, 32'h0);
      $display("setup and fixed wait done");
      stop_test();
   end
endmodule

// *** test/mm_slave_sva.sv ***
module mm_slave_sva
   import mm_slave_pkg::*;
#(
   parameter bit VAR_WAIT = 1'b0
) (
   input wire logic                      clk_in,
   input wire logic                      sys_rst_in,
   input wire mm_slave_pkg::bus_req_t    req_in,
   input wire logic [mm_slave_pkg::CNT_W-1:0] var_delay_in,
   input wire mm_slave_pkg::bus_rsp_t    rsp_out,
   input wire logic                      busy_out,
   input wire logic [31:0]               rd_count_out,
   input wire logic [31:0]               wr_count_out
);
   // ------------------------------------------------------------
   // port checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   logic sel;
   logic stl;
   assign sel = req_in.chip_sel;
   assign stl = rsp_out.stall;
   sequence s_start;
      VAR_WAIT && sel && (req_in.rd || req_in.wr) && var_delay_in != '0
         && !busy_out && !$past(stl);
   endsequence
   a_stall_first: assert property (
      s_start |-> stl) else $error("no stall in first cycle");
   a_stall_ends: assert property (
      $rose(stl) |-> ##[1:260] !stl) else $error("stall never drops");
   a_unsel_quiet: assert property (
      !sel |-> !stl) else $error("stall while unselected");
   a_unsel_nowrite: assert property (
      !sel |=> $stable(wr_count_out)) else $error("write while unselected");
   a_write_counts: assert property (
      sel && req_in.wr && !stl |=> wr_count_out == $past(wr_count_out) + 1)
      else $error("write not taken");
   a_stall_nowrite: assert property (
      sel && req_in.wr && stl |=> $stable(wr_count_out))
      else $error("write taken while stalled");
   a_idle_noread: assert property (
      !(sel && req_in.rd) |=> $stable(rd_count_out))
      else $error("read counted without request");
   a_read_counts: assert property (
      sel && req_in.rd && !stl |=> rd_count_out == $past(rd_count_out) + 1)
      else $error("read not counted at capture");
   a_noreq_nowrite: assert property (
      !req_in.wr |=> $stable(wr_count_out)) else $error("spurious write");
endmodule

bind mm_slave_port_timing mm_slave_sva #(.VAR_WAIT(VAR_WAIT)) i_sva (
   .clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_in(req_in),
   .var_delay_in(var_delay_in), .rsp_out(rsp_out), .busy_out(busy_out),
   .rd_count_out(rd_count_out), .wr_count_out(wr_count_out));

// *** verilog/mm_mem.sv ***
module mm_mem #(
   parameter int unsigned AW    = 8,
   parameter int unsigned DW    = 32,
   parameter int unsigned DEPTH = 256
) (
   input  wire logic            clk_in,
   input  wire logic            we_in,
   input  wire logic [AW-1:0]   waddr_in,
   input  wire logic [DW/8-1:0] wlane_in,
   input  wire logic [DW-1:0]   wdata_in,
   input  wire logic            re_in,
   input  wire logic [AW-1:0]   raddr_in,
   output logic      [DW-1:0]   rdata_out
);

   logic [DW-1:0] mem_r [DEPTH];

   initial begin
      if (DW % 8 != 0 || DEPTH > (1 << AW)) begin
         $error("mm_mem: bad geometry");
      end
   end

   // ------------------------------------------------------------
   // lane-masked write, registered read
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      for (int i = 0; i < DW / 8; i++) begin
         if (we_in && wlane_in[i]) begin
            mem_r[waddr_in][i*8 +: 8] <= wdata_in[i*8 +: 8];
         end
      end
      if (re_in) begin
         rdata_out <= mem_r[raddr_in];
      end
   end

endmodule

// *** verilog/mm_slave_pkg.sv ***
package mm_slave_pkg;

   // ------------------------------------------------------------
   // widths and reset values
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W      = 8;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned LANES       = DATA_W / 8;
   localparam int unsigned DEPTH       = 256;
   localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

   // ------------------------------------------------------------
   // transfer property defaults
   // ------------------------------------------------------------
   localparam int unsigned SETUP_DEF   = 0;
   localparam int unsigned WAIT_DEF    = 1;
   localparam int unsigned CNT_W       = 8;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic              chip_sel;
      logic              rd;
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0]  lane_en;
      logic [DATA_W-1:0] wdata;
   } bus_req_t;

   typedef struct packed {
      logic              stall;
      logic [DATA_W-1:0] rdata;
   } bus_rsp_t;

endpackage

// *** verilog/mm_slave_port_timing.sv ***
module mm_slave_port_timing
   import mm_slave_pkg::*;
#(
   parameter bit          VAR_WAIT  = 1'b0,
   parameter int unsigned SETUP     = SETUP_DEF,
   parameter int unsigned WAITS     = WAIT_DEF,
   parameter bit          HAS_LANES = 1'b1
) (
   input  wire logic                      clk_in,
   input  wire logic                      sys_rst_in,
   input  wire mm_slave_pkg::bus_req_t    req_in,
   input  wire logic [mm_slave_pkg::CNT_W-1:0] var_delay_in,
   output mm_slave_pkg::bus_rsp_t         rsp_out,
   output logic                           busy_out,
   output logic [31:0]                    rd_count_out,
   output logic [31:0]                    wr_count_out
);
   import mm_slave_pkg::*;

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   initial begin
      if (VAR_WAIT && SETUP != 0) begin
         $error("variable wait-states exclude setup time");
      end
      if (!VAR_WAIT && WAITS == 0) begin
         $error("registered read data needs one wait-state");
      end
      if (WAITS >= (1 << CNT_W)) begin
         $error("wait count too wide");
      end
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_STALL = 3'b010,
      ST_DONE  = 3'b100
   } state_t;

   state_t            state_r;
   state_t            state_nxt;
   logic [31:0]       rd_cnt_r;
   logic [31:0]       rd_cnt_nxt;
   logic [31:0]       wr_cnt_r;
   logic [31:0]       wr_cnt_nxt;
   logic              sel_rd;
   logic              sel_wr;
   logic              load;
   logic              cnt_zero;
   logic [LANES-1:0]  lanes;
   logic [CNT_W-1:0]  load_val;
   logic [DATA_W-1:0] mem_rdata;

   // select qualifies every strobe; no select edge is used
   assign sel_rd = req_in.chip_sel && req_in.rd;
   assign sel_wr = req_in.chip_sel && req_in.wr;
   assign lanes  = HAS_LANES ? req_in.lane_en : {LANES{1'b1}};

   // variable delay counts reads and writes alike
   assign load_val = VAR_WAIT ? var_delay_in : CNT_W'(0);
   // with VAR_WAIT, reads stall even at zero delay: read data come from a register
   assign load     = (state_r == ST_IDLE) && VAR_WAIT
                     && (sel_rd || (sel_wr && (var_delay_in != '0)));

   mm_wait_cnt #(
      .CW (CNT_W)
   ) u_cnt (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .load_in    (load),
      .value_in   (load_val),
      .zero_out   (cnt_zero)
   );

   // write lands at the edge where the transfer is accepted
   logic wr_take;
   assign wr_take = sel_wr && !rsp_out.stall;

   mm_mem #(
      .AW    (ADDR_W),
      .DW    (DATA_W),
      .DEPTH (DEPTH)
   ) u_mem (
      .clk_in    (clk_in),
      .we_in     (wr_take),
      .waddr_in  (req_in.addr),
      .wlane_in  (lanes),
      .wdata_in  (req_in.wdata),
      .re_in     (sel_rd),
      .raddr_in  (req_in.addr),
      .rdata_out (mem_rdata)
   );

   // ------------------------------------------------------------
   // stall generation
   // ------------------------------------------------------------
   always_comb begin
      rsp_out.stall = 1'b0;
      if (VAR_WAIT) begin
         case (state_r)
            ST_IDLE: begin
               // raised in the very first cycle
               rsp_out.stall = sel_rd
                               || (sel_wr && (var_delay_in != '0));
            end
            ST_STALL: begin
               rsp_out.stall = !cnt_zero;
            end
            ST_DONE: begin
               rsp_out.stall = 1'b0;
            end
            default: begin
               rsp_out.stall = 1'b0;
            end
         endcase
      end
   end

   // read data from a register; fixed waits give the memory one edge
   assign rsp_out.rdata = mem_rdata;

   // ------------------------------------------------------------
   // next state and counters
   // ------------------------------------------------------------
   always_comb begin
      state_nxt  = state_r;
      rd_cnt_nxt = rd_cnt_r;
      wr_cnt_nxt = wr_cnt_r;
      case (state_r)
         ST_IDLE: begin
            if (load) begin
               state_nxt = ST_STALL;
            end
         end
         ST_STALL: begin
            // back to idle at the capture edge so the next request stalls
            if (cnt_zero) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_DONE: begin
            // transfer ends at this edge, no hold cycles
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      if (wr_take) begin
         wr_cnt_nxt = wr_cnt_r + 32'h0000_0001;
      end
      if (sel_rd && !rsp_out.stall && (!VAR_WAIT || state_r == ST_STALL))
      begin
         rd_cnt_nxt = rd_cnt_r + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_r  <= ST_IDLE;
         rd_cnt_r <= 32'h0000_0000;
         wr_cnt_r <= 32'h0000_0000;
      end else begin
         state_r  <= state_nxt;
         rd_cnt_r <= rd_cnt_nxt;
         wr_cnt_r <= wr_cnt_nxt;
      end
   end

   assign busy_out     = (state_r != ST_IDLE);
   assign rd_count_out = rd_cnt_r;
   assign wr_count_out = wr_cnt_r;

endmodule

// *** verilog/mm_wait_cnt.sv ***
module mm_wait_cnt #(
   parameter int unsigned CW = 8
) (
   input  wire logic          clk_in,
   input  wire logic          sys_rst_in,
   input  wire logic          load_in,
   input  wire logic [CW-1:0] value_in,
   output logic               zero_out
);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;

   // ------------------------------------------------------------
   // down counter
   // ------------------------------------------------------------
   always_comb begin
      cnt_nxt = cnt_r;
      if (load_in) begin
         cnt_nxt = value_in;
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - CW'(1);
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign zero_out = (cnt_r == '0);

endmodule
